// file: design/eprom_prog_pkg.sv
package eprom_prog_pkg;

	localparam int CLK_PERIOD_NS  = 10;
	localparam int ADDR_W         = 13;
	localparam int DATA_W         = 8;
	localparam int CNT_W          = 17;
	localparam int SYNC_STAGES    = 2;

	localparam int T_SETUP_NS     = 2000;
	localparam int T_HOLD_NS      = 2000;
	localparam int T_OUT_EN_NS    = 150;
	localparam int T_PROG_PULSE_US = 1000;

	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC  = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC  = (T_OUT_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
		+ SYNC_STAGES;
	localparam int PROG_PULSE_CYC_DEF = T_PROG_PULSE_US * 1000 / CLK_PERIOD_NS;

	localparam int LOCK_DATA_BIT  = 7;
	localparam int LOCK_ADDR_SET  = 4;
	localparam int LOCK_ADDR_CLR  = 6;
	localparam logic [DATA_W-1:0] DATA_IDLE = 8'hff;

	typedef enum logic [2:0] {
		OP_PROGRAM     = 3'h0,
		OP_VERIFY      = 3'h1,
		OP_READ        = 3'h2,
		OP_LOCK_VERIFY = 3'h3,
		OP_LOCK        = 3'h4,
		OP_DISABLE     = 3'h5
	} op_e;

	typedef enum logic [1:0] {
		S_IDLE  = 2'h0,
		S_SETUP = 2'h1,
		S_PULSE = 2'h2,
		S_HOLD  = 2'h3
	} phase_e;

	typedef struct packed {
		logic              valid;
		op_e               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cmd_s;

	typedef struct packed {
		logic              valid;
		logic              refused;
		logic              match;
		logic              locked;
		logic [DATA_W-1:0] data;
	} resp_s;

	typedef struct packed {
		logic              chipSelect_n;
		logic              outputEnable_n;
		logic              program_strobe_n;
		logic              vppHigh;
		logic              test_mode_select;
		logic              oscillator_input;
		logic              device_reset_input;
		logic [ADDR_W-1:0] byte_address_lines;
		logic [DATA_W-1:0] dataOut;
		logic              dataOe_n;
	} pins_s;

endpackage

// file: design/eprom_programmer.sv
`timescale 1ns/1ps
`default_nettype none

module eprom_programmer
	import eprom_prog_pkg::*;
#(
	parameter int PROG_PULSE_CYC = PROG_PULSE_CYC_DEF
) (
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire cmd_s              cmdIn,
	output var  logic              cmdReady,
	output var  resp_s             resp,
	output var  pins_s             pins,
	input  wire logic [DATA_W-1:0] byteDataIn
);

	typedef struct packed {
		phase_e            phase;
		logic [CNT_W-1:0]  count;
		cmd_s              cmd;
		logic              verifyOk;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
		logic              ready;
		resp_s             resp;
		pins_s             pins;
	} state_s;

	state_s stReg;
	state_s stNext;

	function automatic pins_s idlePins();
		pins_s p;
		p.chipSelect_n       = 1'b1;
		p.outputEnable_n     = 1'b1;
		p.program_strobe_n   = 1'b1;
		p.vppHigh            = 1'b0;
		p.test_mode_select   = 1'b0;
		p.oscillator_input   = 1'b0;
		p.device_reset_input = 1'b0;
		p.byte_address_lines = '0;
		p.dataOut            = DATA_IDLE;
		p.dataOe_n           = 1'b1;
		return p;
	endfunction

	// Static levels of each mode, outside the active pulse.
	function automatic pins_s modePins(input cmd_s c);
		pins_s p;
		p = idlePins();
		p.byte_address_lines = c.addr;
		case (c.op)
			OP_PROGRAM: begin
				p.chipSelect_n = 1'b0;
				p.vppHigh      = 1'b1;
				p.dataOut      = c.data;
				p.dataOe_n     = 1'b0;
			end
			OP_VERIFY: begin
				p.chipSelect_n = 1'b0;
				p.vppHigh      = 1'b1;
			end
			OP_READ: begin
				p.chipSelect_n = 1'b0;
			end
			OP_LOCK_VERIFY: begin
				p.chipSelect_n     = 1'b0;
				p.outputEnable_n   = 1'b0;
				p.test_mode_select = 1'b1;
				p.byte_address_lines[LOCK_ADDR_CLR] = 1'b0;
			end
			OP_LOCK: begin
				p.vppHigh          = 1'b1;
				p.test_mode_select = 1'b1;
				p.byte_address_lines[LOCK_ADDR_SET] = 1'b1;
				p.dataOut  = DATA_IDLE;
				p.dataOe_n = 1'b0;
			end
			default: begin
				p = idlePins();
			end
		endcase
		return p;
	endfunction

	function automatic logic [CNT_W-1:0] pulseLen(input op_e op);
		case (op)
			OP_PROGRAM, OP_LOCK: pulseLen = CNT_W'(PROG_PULSE_CYC);
			default:             pulseLen = CNT_W'(READ_CYC);
		endcase
	endfunction

	always_comb begin
		stNext = stReg;
		stNext.sync1 = byteDataIn;
		stNext.sync2 = stReg.sync1;
		stNext.resp.valid = 1'b0;
		if (stReg.count != '0) begin
			stNext.count = stReg.count - CNT_W'(1);
		end
		case (stReg.phase)
			S_IDLE: begin
				if (cmdIn.valid && stReg.ready) begin
					stNext.cmd = cmdIn;
					if (cmdIn.op == OP_LOCK && !stReg.verifyOk) begin
						stNext.resp.valid   = 1'b1;
						stNext.resp.refused = 1'b1;
					end else begin
						stNext.phase = S_SETUP;
						stNext.count = CNT_W'(SETUP_CYC - 1);
						stNext.pins  = modePins(cmdIn);
					end
				end
			end
			S_SETUP: begin
				if (stReg.count == '0) begin
					stNext.phase = S_PULSE;
					stNext.count = pulseLen(stReg.cmd.op) - CNT_W'(1);
					case (stReg.cmd.op)
						OP_PROGRAM: stNext.pins.program_strobe_n = 1'b0;
						OP_VERIFY, OP_READ: stNext.pins.outputEnable_n = 1'b0;
						OP_LOCK: stNext.pins.dataOut[LOCK_DATA_BIT] = 1'b0;
						default: stNext.pins.outputEnable_n = stReg.pins.outputEnable_n;
					endcase
				end
			end
			S_PULSE: begin
				if (stReg.count == '0) begin
					stNext.phase = S_HOLD;
					stNext.count = CNT_W'(HOLD_CYC - 1);
					stNext.pins.program_strobe_n = 1'b1;
					stNext.pins.outputEnable_n   = 1'b1;
					stNext.pins.dataOut[LOCK_DATA_BIT] = stReg.cmd.data[LOCK_DATA_BIT];
					stNext.resp.data    = stReg.sync2;
					stNext.resp.match   = stReg.sync2 == stReg.cmd.data;
					stNext.resp.locked  = stReg.sync2[LOCK_DATA_BIT];
					stNext.resp.refused = 1'b0;
					case (stReg.cmd.op)
						// New code invalidates any earlier verification.
						OP_PROGRAM: stNext.verifyOk = 1'b0;
						OP_VERIFY, OP_READ:
							stNext.verifyOk = stReg.sync2 == stReg.cmd.data;
						default: stNext.verifyOk = stReg.verifyOk;
					endcase
				end
			end
			S_HOLD: begin
				// Data and address stay put through the hold time.
				if (stReg.count == '0) begin
					stNext.phase = S_IDLE;
					stNext.pins  = idlePins();
					stNext.resp.valid = 1'b1;
				end
			end
			default: begin
				stNext.phase = S_IDLE;
				stNext.pins  = idlePins();
			end
		endcase
		stNext.ready = stNext.phase == S_IDLE;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stReg          <= '0;
			stReg.phase    <= S_IDLE;
			stReg.pins     <= idlePins();
			stReg.resp     <= '0;
			stReg.ready    <= 1'b1;
		end else begin
			stReg <= stNext;
		end
	end

	assign cmdReady = stReg.ready;
	assign resp     = stReg.resp;
	assign pins     = stReg.pins;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	logic [CNT_W-1:0] lowRun;
	always_ff @(posedge core_clk) begin
		if (!rst_b || pins.program_strobe_n) begin
			lowRun <= '0;
		end else begin
			lowRun <= lowRun + CNT_W'(1);
		end
	end

	sequence strobeFall;
		$fell(pins.program_strobe_n);
	endsequence

	prog_levels_a: assert property (!pins.program_strobe_n |->
		!pins.chipSelect_n && !pins.outputEnable_n == 1'b0 && pins.vppHigh
		&& !pins.dataOe_n)
		else $error("program strobe low with wrong levels");

	prog_width_a: assert property ($rose(pins.program_strobe_n) |->
		$past(lowRun) == CNT_W'(PROG_PULSE_CYC - 1))
		else $error("program pulse of wrong length");

	prog_setup_a: assert property (strobeFall |->
		$past(!pins.chipSelect_n, SETUP_CYC))
		else $error("chip select setup too short");

	read_levels_a: assert property ($fell(pins.outputEnable_n) &&
		!pins.test_mode_select |-> !pins.chipSelect_n && pins.dataOe_n
		&& pins.program_strobe_n)
		else $error("read pulse with wrong levels");

	verify_resp_a: assert property ($rose(pins.outputEnable_n) &&
		stReg.cmd.op == OP_VERIFY |-> ##200 resp.valid)
		else $error("verify answer not on time");

	lock_pulse_a: assert property ($fell(pins.dataOut[LOCK_DATA_BIT]) &&
		pins.test_mode_select |-> pins.chipSelect_n && pins.outputEnable_n
		&& pins.program_strobe_n
		&& pins.byte_address_lines[LOCK_ADDR_SET])
		else $error("lock pulse with wrong levels");

	lock_verify_a: assert property (pins.test_mode_select &&
		!pins.outputEnable_n |-> !pins.chipSelect_n && pins.dataOe_n
		&& !pins.byte_address_lines[LOCK_ADDR_CLR])
		else $error("lock verify with wrong levels");

	lock_guard_a: assert property (cmdIn.valid && cmdReady &&
		cmdIn.op == OP_LOCK && !stReg.verifyOk |=>
		resp.valid && resp.refused && stReg.phase == S_IDLE)
		else $error("lock accepted without verification");

	addr_stable_a: assert property (stReg.phase == S_PULSE |=>
		$stable(pins.byte_address_lines))
		else $error("address moved during pulse");

	float_idle_a: assert property (pins.chipSelect_n &&
		pins.outputEnable_n && !pins.test_mode_select |->
		pins.dataOe_n)
		else $error("data driven in output disable");

endmodule

`default_nettype wire

// file: design/eprom_prog_pkg_dummy_none.sv
`timescale 1ns/1ps

// file: tb/eprom_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module eprom_device_model
	import eprom_prog_pkg::*;
(
	input  wire pins_s             pins,
	input  wire logic [DATA_W-1:0] dataBus,
	output var  logic [DATA_W-1:0] devData,
	output var  logic              devOe_n
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic              lockBit;
	logic              arrRd;
	logic              lockRd;

	// The part arrives erased: every bit one and the lock clear.
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		lockBit = 1'b0;
	end

	// Programming only clears bits, so the cell keeps old AND new.
	always @(negedge pins.program_strobe_n) begin
		if (!pins.chipSelect_n && pins.outputEnable_n && pins.vppHigh)
			mem[pins.byte_address_lines] &= dataBus;
	end

	// No pin sequence clears the lock; only a fresh, erased part does.
	always @(negedge dataBus[LOCK_DATA_BIT]) begin
		if (pins.chipSelect_n && pins.outputEnable_n && pins.program_strobe_n
			&& pins.test_mode_select && pins.vppHigh
			&& pins.byte_address_lines[LOCK_ADDR_SET])
			lockBit = 1'b1;
	end

	assign arrRd = !pins.chipSelect_n && !pins.outputEnable_n
		&& pins.program_strobe_n && !pins.test_mode_select
		&& !lockBit;
	assign lockRd = !pins.chipSelect_n && !pins.outputEnable_n
		&& pins.test_mode_select
		&& !pins.byte_address_lines[LOCK_ADDR_CLR];
	assign devOe_n = !(arrRd || lockRd);
	// A programmed lock bit reads low, like any programmed cell.
	assign devData = lockRd ? {~lockBit, 7'h7f}
		: mem[pins.byte_address_lines];
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import eprom_prog_pkg::*;
;
	logic              core_clk;
	logic              rst_b;
	cmd_s              cmdIn;
	logic              cmdReady;
	resp_s             resp;
	resp_s             got;
	pins_s             pins;
	logic [DATA_W-1:0] devData;
	logic              devOe_n;
	logic [DATA_W-1:0] busLast;
	wire  [DATA_W-1:0] dataBus;
	int                badCount;
	int                comparisons;
	int                driveCount;

	// A released bus shows a changing pattern, never a held value.
	assign dataBus = !pins.dataOe_n ? pins.dataOut
		: !devOe_n ? devData : ~busLast;

	eprom_programmer #(.PROG_PULSE_CYC(20)) u_eprom_programmer (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.cmdIn     (cmdIn),
		.cmdReady  (cmdReady),
		.resp      (resp),
		.pins      (pins),
		.byteDataIn(dataBus)
	);
	eprom_device_model u_eprom_device_model (
		.pins   (pins),
		.dataBus(dataBus),
		.devData(devData),
		.devOe_n(devOe_n)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		busLast <= dataBus;
		if (devOe_n === 1'b0)
			driveCount++;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] val);
		comparisons++;
		if (val !== exp) begin
			badCount++;
			$display("BAD %s expected %h seen %h", what, exp, val);
		end
	endtask

	task automatic doCmd(input op_e op, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		while (cmdReady !== 1'b1) begin
			@(posedge core_clk);
			#1;
		end
		cmdIn = '{1'b1, op, a, d};
		@(posedge core_clk);
		#1;
		cmdIn.valid = 1'b0;
		while (resp.valid !== 1'b1 && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		got = resp;
		chk("answer", 32'h1, {31'h0, resp.valid});
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic testRefuse();
		doCmd(OP_LOCK, 13'h0000, 8'hff);
		chk("refused", 32'h1, {31'h0, got.refused});
	endtask

	task automatic testProgram();
		doCmd(OP_PROGRAM, 13'h1fff, 8'h5a);
		doCmd(OP_PROGRAM, 13'h1fff, 8'h0f);
		doCmd(OP_PROGRAM, 13'h0100, 8'h00);
		doCmd(OP_READ, 13'h0100, 8'h00);
		chk("zero fill", 32'h00, {24'h0, got.data});
		doCmd(OP_READ, 13'h1fff, 8'h0a);
		chk("read data", 32'h0a, {24'h0, got.data});
		chk("read match", 32'h1, {31'h0, got.match});
		doCmd(OP_VERIFY, 13'h0000, 8'hff);
		chk("erased", 32'hff, {24'h0, got.data});
		doCmd(OP_DISABLE, 13'h0000, 8'hff);
	endtask

	task automatic testLock();
		doCmd(OP_LOCK_VERIFY, 13'h0000, 8'hff);
		chk("open lock", 32'h1, {31'h0, got.locked});
		doCmd(OP_VERIFY, 13'h1fff, 8'h0a);
		chk("verify", 32'h1, {31'h0, got.match});
		doCmd(OP_LOCK, 13'h0010, 8'hff);
		chk("lock taken", 32'h0, {31'h0, got.refused});
		doCmd(OP_LOCK_VERIFY, 13'h0000, 8'hff);
		chk("set lock", 32'h0, {31'h0, got.locked});
		driveCount = 0;
		doCmd(OP_READ, 13'h1fff, 8'h0a);
		chk("locked read", 32'h0, driveCount);
	endtask

	initial begin
		rst_b = 1'b0;
		cmdIn = '0;
		busLast = 8'h00;
		badCount = 0;
		comparisons = 0;
		driveCount = 0;
		repeat (10) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		chk("idle pins", {3'h0, 29'h1c0001ff}, {3'h0, pins});
		testRefuse();
		testProgram();
		testLock();
		finish_test();
	end

	// Twelve commands of about 420 cycles each, and one refused at once, fit well inside this span.
	initial begin
		repeat (30000) @(posedge core_clk);
		badCount++;
		finish_test();
	end
endmodule
`default_nettype wire
